/* rtl/dwu_top.sv */
// Dual watchdog unit: APB registers, independent watchdog, window glue
`default_nettype none
// Overview of operation
// - Independent: 12-bit down-counter behind 3-bit prescaler
// - Independent runs from own oscillator, all states
// - Independent resets system when counter reaches zero
// - Option strap selects hardware or software start
// - Independent gives reset and low-power wake-up
// - Window: 7-bit counter, bus clock over 4096
// - Window resets when counter drops below 0x40
// - Window resets on reload above window value
// - Window early warning when counter equals 0x40
// - Independent never stopped in standby state
module dwu_top (
  // Clock and reset
  input  wire logic        mclk_i,
  input  wire logic        sys_rst_i,
  // APB slave
  input  wire logic [11:0] paddr_i,
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [31:0] pwdata_i,
  output var  logic [31:0] prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  // Oscillator, strap and power state
  input  wire logic        lsi_clk_i,
  input  wire logic        hw_start_i,
  input  wire logic        deep_stop_state_i,
  input  wire logic        standby_i,
  // System outputs
  output var  logic        watchdog_reset_o,
  output var  logic        lp_wakeup_o,
  output logic             early_warning_interrupt_o
);
  // Bus decode
  logic        wr_acc;     // Write access phase
  logic        rd_setup;   // Read setup phase
  logic        mapped;     // Address hits a register
  logic [31:0] rd_mux;     // Read data selection

  // Independent watchdog state
  logic [2:0]  ind_presc;    // Prescaler setting
  logic [11:0] ind_reload;   // Start value
  logic [11:0] ind_cnt;      // Down-counter
  logic        ind_running;  // Activated
  logic [8:0]  ind_pcnt;     // Prescaler count
  logic [8:0]  ind_plast;    // Prescaler terminal
  logic        ind_tick;     // Prescaled step
  logic        key_start;
  logic        key_refresh;
  logic        low_power;

  // Oscillator synchroniser and filter
  logic        lsi_s1;
  logic        lsi_s2;
  logic        lsi_s3;
  logic        lsi_filt;
  logic        lsi_rise;

  // Strap capture
  logic        strap_done;
  logic        hw_start_q;

  // Window watchdog glue
  logic [11:0] win_div;   // Bus clock divider
  logic        win_tick;
  logic [6:0]  win_window;
  logic        win_ewi_en;
  dwu_win_if   win ();

  // Either low-power input gates the bus clock side
  assign low_power = deep_stop_state_i || standby_i;

  // APB handshake: zero wait states, error on unmapped
  assign pready_o  = 1'b1;
  assign wr_acc    = psel_i && penable_i && pwrite_i;
  assign rd_setup  = psel_i && !penable_i && !pwrite_i;
  assign pslverr_o = psel_i && penable_i && !mapped;

  always_comb begin
    mapped = 1'b1;
    rd_mux = 32'h0000_0000;
    case (paddr_i)
      dwu_pkg::OFS_IND_KEY:    rd_mux = 32'h0000_0000;  // Write-only
      dwu_pkg::OFS_IND_PRESC:  rd_mux = {29'h0000_0000, ind_presc};
      dwu_pkg::OFS_IND_RELOAD: rd_mux = {20'h0_0000, ind_reload};
      dwu_pkg::OFS_IND_STATUS: rd_mux = {19'h0_0000, ind_running, ind_cnt};
      dwu_pkg::OFS_WIN_CTRL:   rd_mux = {24'h00_0000, win.enabled, win.count};
      dwu_pkg::OFS_WIN_CFG:    rd_mux = {23'h00_0000, win_ewi_en, 1'b0, win_window};
      dwu_pkg::OFS_WIN_STATUS: rd_mux = {30'h0000_0000, win.rst_req, win.ew_flag};
      default:                 mapped = 1'b0;
    endcase
  end

  // Read data captured in setup, stable through access
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      prdata_o <= 32'h0000_0000;
    end else if (rd_setup) begin
      prdata_o <= rd_mux;
    end
  end

  // Key decode: only the exact codes in bits 15:0 act, bits 31:16 are not checked
  assign key_start   = wr_acc && paddr_i == dwu_pkg::OFS_IND_KEY &&
                       pwdata_i[15:0] == dwu_pkg::KEY_START;
  assign key_refresh = wr_acc && paddr_i == dwu_pkg::OFS_IND_KEY &&
                       pwdata_i[15:0] == dwu_pkg::KEY_REFRESH;

  // Independent configuration registers
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      ind_presc  <= dwu_pkg::IND_PRESC_RST;
      ind_reload <= dwu_pkg::IND_RELOAD_RST;
    end else if (wr_acc) begin
      if (paddr_i == dwu_pkg::OFS_IND_PRESC) begin
        ind_presc <= pwdata_i[2:0];
      end
      if (paddr_i == dwu_pkg::OFS_IND_RELOAD) begin
        ind_reload <= pwdata_i[11:0];
      end
    end
  end

  // Oscillator pin: three stages, change counts when stages 2 and 3 agree
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      lsi_s1 <= 1'b0;
      lsi_s2 <= 1'b0;
      lsi_s3 <= 1'b0;
    end else begin
      lsi_s1 <= lsi_clk_i;
      lsi_s2 <= lsi_s1;
      lsi_s3 <= lsi_s2;
    end
  end

  // Filtered oscillator level
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      lsi_filt <= 1'b1;  // Starts high: no false rise after reset
    end else if (lsi_s2 == lsi_s3) begin
      lsi_filt <= lsi_s3;
    end
  end

  // One rising step per settled oscillator period
  assign lsi_rise = (lsi_s2 == lsi_s3) && lsi_s3 && !lsi_filt;

  // Prescaler: divide by 4 << setting; ignores power state on purpose
  assign ind_plast = 9'((dwu_pkg::IND_DIV_BASE << ind_presc) - 10'h001);
  assign ind_tick  = lsi_rise && ind_pcnt == ind_plast;

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      ind_pcnt <= 9'h000;
    end else if (key_start || key_refresh) begin
      ind_pcnt <= 9'h000;  // Fresh period after reload
    end else if (lsi_rise) begin
      ind_pcnt <= (ind_pcnt >= ind_plast) ? 9'h000 : ind_pcnt + 9'h001;
    end
  end

  // Strap caught on the first cycle after reset release
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      strap_done <= 1'b0;
      hw_start_q <= 1'b0;
    end else if (!strap_done) begin
      strap_done <= 1'b1;
      hw_start_q <= hw_start_i;
    end
  end

  // Activation: strap or start key; only reset stops it
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      ind_running <= 1'b0;
    end else if ((!strap_done && hw_start_i) || key_start) begin
      ind_running <= 1'b1;
    end
  end

  // Independent counter: reload on start or refresh, else step down
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      ind_cnt <= dwu_pkg::IND_RELOAD_RST;
    end else if (key_refresh || key_start || (!strap_done && hw_start_i)) begin
      ind_cnt <= ind_reload;
    end else if (ind_running && ind_tick && ind_cnt != 12'h000) begin
      ind_cnt <= ind_cnt - 12'h001;
    end
  end

  // System reset: held until the chip reset clears the unit
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      watchdog_reset_o <= 1'b0;
    end else if ((ind_running && ind_cnt == 12'h000) || win.rst_req) begin
      watchdog_reset_o <= 1'b1;
    end
  end

  // Wake-up pulse when the independent side fires in low power
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      lp_wakeup_o <= 1'b0;
    end else begin
      lp_wakeup_o <= low_power && ind_running && ind_cnt == 12'h000 &&
                     !watchdog_reset_o;
    end
  end

  // Window divider; bus clock is gated off in the low-power states
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      win_div <= 12'h000;
    end else if (!low_power) begin
      win_div <= (win_div == dwu_pkg::WIN_DIV_LAST) ? 12'h000 : win_div + 12'h001;
    end
  end

  // Count enable for the window core, one cycle long
  assign win_tick = !low_power && win_div == dwu_pkg::WIN_DIV_LAST;

  // Window configuration register
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      win_window <= dwu_pkg::WIN_WINDOW_RST;
      win_ewi_en <= 1'b0;
    end else if (wr_acc && paddr_i == dwu_pkg::OFS_WIN_CFG) begin
      win_window <= pwdata_i[6:0];
      win_ewi_en <= pwdata_i[dwu_pkg::WIN_EWI_BIT];
    end
  end

  // Window core hookup
  assign win.tick      = win_tick;
  assign win.ctrl_wr   = wr_acc && paddr_i == dwu_pkg::OFS_WIN_CTRL;
  assign win.ctrl_data = pwdata_i[7:0];
  assign win.window    = win_window;
  assign win.ewi_en    = win_ewi_en;
  assign win.ewi_clr   = wr_acc && paddr_i == dwu_pkg::OFS_WIN_STATUS && pwdata_i[0];

  // Warning line follows the flag only while permitted
  assign early_warning_interrupt_o = win.ew_flag && win_ewi_en;

  dwu_window_watchdog u_win (
    .mclk_i    (mclk_i),
    .sys_rst_i (sys_rst_i),
    .w         (win)
  );

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (sys_rst_i);

  // Refresh key seen by a running watchdog
  sequence s_refresh;
    key_refresh && ind_running;
  endsequence

  // Running independent counter standing at zero
  sequence s_expiry;
    ind_running && ind_cnt == 12'h000;
  endsequence

  // Independent side checks
  AST_IND_ZERO_RST: assert property (s_expiry |=> watchdog_reset_o)
    else $error("independent expiry without reset");
  AST_IND_REFRESH: assert property (s_refresh |=> ind_cnt == $past(ind_reload))
    else $error("refresh did not reload independent counter");
  AST_IND_LP_RUN: assert property (low_power && ind_running && ind_tick
                    && ind_cnt != 12'h000 && !key_refresh && !key_start
                    |=> ind_cnt == $past(ind_cnt) - 12'h001)
    else $error("independent counter stalled in low power");
  AST_IND_DEC: assert property (ind_running && ind_tick && ind_cnt != 12'h000
                 && !key_refresh && !key_start |=> ind_cnt == $past(ind_cnt) - 12'h001)
    else $error("independent counter missed a prescaled step");
  AST_IND_PRESC: assert property (ind_tick |=> ind_pcnt == 9'h000)
    else $error("prescaler did not restart after a step");
  AST_IND_START: assert property (key_start |=>
                   ind_running && ind_cnt == $past(ind_reload))
    else $error("start key did not load and run the counter");
  AST_IND_HW_START: assert property (strap_done && hw_start_q |-> ind_running)
    else $error("hardware start strap ignored");
  AST_IND_NO_STOP: assert property (ind_running |=> ind_running)
    else $error("independent watchdog stopped while running");
  AST_IND_WAKE: assert property (s_expiry ##0 (low_power && !watchdog_reset_o)
                  |=> lp_wakeup_o && watchdog_reset_o)
    else $error("no wake-up on low-power expiry");
  AST_WAKE_PULSE: assert property (lp_wakeup_o |=> !lp_wakeup_o)
    else $error("wake-up pulse longer than one cycle");

  // Shared reset and window hookup checks
  AST_RST_STICKY: assert property (watchdog_reset_o |=> watchdog_reset_o)
    else $error("system reset request dropped");
  AST_WIN_TO_SYS: assert property (win.rst_req |=> watchdog_reset_o)
    else $error("window reset request not passed on");
  AST_WIN_TICK_GAP: assert property (win_tick |=> !win_tick [*8])
    else $error("window ticks too close");
endmodule
`default_nettype wire

/* rtl/dwu_window_watchdog.sv */
// Window watchdog core: 7-bit counter, window check, early warning
`default_nettype none
module dwu_window_watchdog (
  // Clock and reset
  input  wire logic mclk_i,
  input  wire logic sys_rst_i,
  // Control link
  dwu_win_if.core   w
);
  logic [6:0] count;    // Down-counter
  logic       enabled;  // Once set, only reset clears it
  logic       ew_flag;  // Warning flag
  logic       rst_req;  // Reset request
  logic       early_ref;
  logic       accept;

  assign w.count   = count;
  assign w.enabled = enabled;
  assign w.ew_flag = ew_flag;
  assign w.rst_req = rst_req;

  // Reload while still above the window is a fault
  assign early_ref = w.ctrl_wr && enabled && (count > w.window);
  assign accept    = w.ctrl_wr && !early_ref;

  // Counter: reload wins over the tick, otherwise free-running
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      count <= dwu_pkg::WIN_CNT_RST;
    end else if (accept) begin
      count <= w.ctrl_data[6:0];
    end else if (w.tick && !early_ref) begin
      // Early refresh freezes the count while the reset goes out
      count <= count - 7'h01;
    end
  end

  // Enable: software can start but never stop it
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      enabled <= 1'b0;
    end else if (accept && w.ctrl_data[dwu_pkg::WIN_EN_BIT]) begin
      enabled <= 1'b1;
    end
  end

  // Reset request: top bit clear or early refresh
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      rst_req <= 1'b0;
    end else if (enabled && (!count[6] || early_ref)) begin
      rst_req <= 1'b1;
    end
  end

  // Warning flag: set on the step to 0x40, set beats clear
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      ew_flag <= 1'b0;
    end else if (w.tick && !w.ctrl_wr && enabled && w.ewi_en &&
                 count == dwu_pkg::WIN_WARN_PRE) begin
      ew_flag <= 1'b1;
    end else if (w.ewi_clr) begin
      ew_flag <= 1'b0;
    end
  end

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (sys_rst_i);

  // Step to the warning value
  sequence s_warn_step;
    w.tick && !w.ctrl_wr && enabled && w.ewi_en && count == dwu_pkg::WIN_WARN_PRE;
  endsequence

  AST_WIN_FLOOR_RST: assert property (enabled && !count[6] |=> rst_req)
    else $error("window counter below floor without reset");
  AST_WIN_EARLY_RST: assert property (early_ref |=> rst_req && $stable(count))
    else $error("early reload did not reset");
  AST_WIN_WARN: assert property (s_warn_step |=>
                  ew_flag && count == dwu_pkg::WIN_FLOOR)
    else $error("early warning missing at 0x40");
  AST_WIN_DEC: assert property (w.tick && !w.ctrl_wr |=> count == $past(count) - 7'h01)
    else $error("window counter did not decrement");
  AST_WIN_RELOAD: assert property (accept |=> count == $past(w.ctrl_data[6:0]))
    else $error("accepted reload not loaded");
endmodule
`default_nettype wire

/* shared/dwu_pkg.sv */
// Shared constants of the dual watchdog unit
`default_nettype none
package dwu_pkg;
  // Register byte offsets
  localparam logic [11:0] OFS_IND_KEY    = 12'h000;
  localparam logic [11:0] OFS_IND_PRESC  = 12'h004;
  localparam logic [11:0] OFS_IND_RELOAD = 12'h008;
  localparam logic [11:0] OFS_IND_STATUS = 12'h00C;
  localparam logic [11:0] OFS_WIN_CTRL   = 12'h010;
  localparam logic [11:0] OFS_WIN_CFG    = 12'h014;
  localparam logic [11:0] OFS_WIN_STATUS = 12'h018;
  // Key codes written to the independent key register
  localparam logic [15:0] KEY_START   = 16'hCCCC;
  localparam logic [15:0] KEY_REFRESH = 16'hAAAA;
  // Field positions
  localparam int IND_RUN_BIT = 12;  // Status: running flag
  localparam int WIN_EN_BIT  = 7;   // Control: enable
  localparam int WIN_EWI_BIT = 8;   // Config: warning interrupt enable
  // Values after reset
  localparam logic [11:0] IND_RELOAD_RST = 12'hFFF;
  localparam logic [2:0]  IND_PRESC_RST  = 3'h0;
  localparam logic [6:0]  WIN_CNT_RST    = 7'h7F;
  localparam logic [6:0]  WIN_WINDOW_RST = 7'h7F;
  // Window counter landmarks
  localparam logic [6:0]  WIN_FLOOR      = 7'h40;
  localparam logic [6:0]  WIN_WARN_PRE   = 7'h41;
  // Window tick divider, bus clock cycles per count
  localparam int          WIN_DIV        = 4096;
  localparam logic [11:0] WIN_DIV_LAST   = 12'(WIN_DIV - 1);
  // Independent prescaler: divide by 4 shifted by the setting
  localparam logic [9:0]  IND_DIV_BASE   = 10'h004;
endpackage
`default_nettype wire

/* shared/dwu_win_if.sv */
// Link between the unit top and its window watchdog core
`default_nettype none
interface dwu_win_if;
  logic       tick;       // One-cycle count enable
  logic       ctrl_wr;    // Software write of the control word
  logic [7:0] ctrl_data;  // Enable and counter value written
  logic [6:0] window;     // Programmed window value
  logic       ewi_en;     // Early warning permitted
  logic       ewi_clr;    // Clear of the warning flag
  logic [6:0] count;      // Present counter
  logic       enabled;    // Watchdog started
  logic       ew_flag;    // Sticky early warning
  logic       rst_req;    // Sticky reset request
  modport ctl  (output tick, ctrl_wr, ctrl_data, window, ewi_en, ewi_clr,
                input  count, enabled, ew_flag, rst_req);
  modport core (input  tick, ctrl_wr, ctrl_data, window, ewi_en, ewi_clr,
                output count, enabled, ew_flag, rst_req);
endinterface
`default_nettype wire

/* testbench/test_dwu_top.sv */
// Self-checking bench of the dual watchdog unit over its APB port
`default_nettype none
module test_dwu_top;
  timeunit 1ns;
  timeprecision 1ps;
  // Compare two values, count and report
  `define CHK(a, b) begin checks++; if ((a) !== (b)) begin err_count++; \
    $display("BAD t=%0t got %h exp %h", $time, (a), (b)); end end
  logic        mclk_i = 1'b0;     // Bus clock
  logic        sys_rst_i = 1'b1;  // Sync reset
  logic [11:0] paddr_i = 12'h000; // APB address
  logic        psel_i = 1'b0;
  logic        penable_i = 1'b0;
  logic        pwrite_i = 1'b0;
  logic [31:0] pwdata_i = 32'h0000_0000;
  logic [31:0] prdata_o;
  logic        pready_o;
  logic        pslverr_o;
  logic        lsi_clk_i = 1'b0;  // Slow oscillator
  logic        hw_start_i = 1'b0; // Option strap
  logic        deep_stop_state_i = 1'b0;
  logic        standby_i = 1'b0;
  logic        watchdog_reset_o;
  logic        lp_wakeup_o;
  logic        early_warning_interrupt_o;
  int          err_count = 0;     // Mismatches
  int          checks = 0;        // Comparisons
  int          cyc = 0;           // Timeout counter
  int          n;                 // Measured wait
  logic [31:0] rd;                // Last read data
  logic        er;                // Last slave error
  logic [2:0]  lsi_div = 3'h0;    // Oscillator divider
  dwu_top u_dwu_top (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .paddr_i(paddr_i),
    .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .pwdata_i(pwdata_i),
    .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
    .lsi_clk_i(lsi_clk_i), .hw_start_i(hw_start_i),
    .deep_stop_state_i(deep_stop_state_i), .standby_i(standby_i),
    .watchdog_reset_o(watchdog_reset_o), .lp_wakeup_o(lp_wakeup_o),
    .early_warning_interrupt_o(early_warning_interrupt_o));
  // 100 MHz clock
  always #5 mclk_i = ~mclk_i;
  // Slow oscillator, eight bus cycles a period, far below the filter rate
  always @(posedge mclk_i) begin
    lsi_div <= lsi_div + 3'h1;
    if (lsi_div == 3'h3 || lsi_div == 3'h7) begin
      lsi_clk_i <= ~lsi_clk_i;
    end
  end
  // Hang guard, well above the three window ticks needed
  always @(posedge mclk_i) begin
    cyc++;
    if (cyc == 60000) begin
      err_count++;
      wrap_up();
    end
  end
  // Verdict
  task automatic wrap_up();
    $display("checks=%0d errors=%0d", checks, err_count);
    if (err_count == 0 && checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // One APB transfer: setup, then access until pready
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel_i    <= 1'b1;
    penable_i <= 1'b0;
    pwrite_i  <= w;
    paddr_i   <= a;
    pwdata_i  <= d;
    @(posedge mclk_i);
    penable_i <= 1'b1;
    do @(posedge mclk_i); while (pready_o !== 1'b1);
    rd = prdata_o;
    er = pslverr_o;
    psel_i    <= 1'b0;
    penable_i <= 1'b0;
    // One idle edge, so a following call never re-drives in this step
    @(posedge mclk_i);
  endtask
  // Reset for six cycles with the given strap
  task automatic do_reset(input logic hw);
    hw_start_i <= hw;
    sys_rst_i  <= 1'b1;
    repeat (6) @(posedge mclk_i);
    sys_rst_i <= 1'b0;
    @(posedge mclk_i);
  endtask
  // Cycles until the system reset shows, bounded
  task automatic wait_rst(input int lim, output int cnt);
    cnt = 0;
    while (watchdog_reset_o !== 1'b1 && cnt < lim) begin
      @(posedge mclk_i);
      cnt++;
    end
  endtask
  // Poll window counter until it shows a value
  task automatic wait_cnt(input logic [6:0] v);
    int k;
    k = 0;
    do begin
      apb(1'b0, dwu_pkg::OFS_WIN_CTRL, 32'h0000_0000);
      k++;
    end while (rd[6:0] !== v && k < 2500);
  endtask
  initial begin
    do_reset(1'b0);
    // Reset values, an always-ready bus and the unmapped hole
    apb(1'b0, dwu_pkg::OFS_IND_PRESC, 32'h0000_0000);
    `CHK(rd, 32'h0000_0000)
    `CHK(pready_o, 1'b1)
    apb(1'b0, dwu_pkg::OFS_IND_RELOAD, 32'h0000_0000);
    `CHK(rd, 32'h0000_0FFF)
    apb(1'b0, dwu_pkg::OFS_WIN_CFG, 32'h0000_0000);
    `CHK(rd, 32'h0000_007F)
    apb(1'b0, dwu_pkg::OFS_IND_STATUS, 32'h0000_0000);
    `CHK(rd[12], 1'b0)
    apb(1'b0, 12'h01C, 32'h0000_0000);
    `CHK({er, rd}, {1'b1, 32'h0000_0000})
    // Independent expiry at three prescaler settings, low power in two runs
    for (int p = 0; p < 3; p++) begin
      do_reset(1'b0);
      standby_i         <= (p == 0);
      deep_stop_state_i <= (p == 1);
      apb(1'b1, dwu_pkg::OFS_IND_PRESC, 32'(p));
      apb(1'b1, dwu_pkg::OFS_IND_RELOAD, 32'h0000_0003);
      apb(1'b1, dwu_pkg::OFS_IND_KEY, 32'(dwu_pkg::KEY_START));
      apb(1'b0, dwu_pkg::OFS_IND_STATUS, 32'h0000_0000);
      `CHK(rd[12], 1'b1)
      // Refreshes in time keep the system alive
      repeat (8) begin
        repeat (20) @(posedge mclk_i);
        apb(1'b1, dwu_pkg::OFS_IND_KEY, 32'(dwu_pkg::KEY_REFRESH));
      end
      `CHK(watchdog_reset_o, 1'b0)
      wait_rst(2000, n);
      // Three counts of 4<<p slow edges, eight cycles each
      `CHK(n >= (2 * (4 << p)) * 8, 1'b1)
      `CHK(n <= (3 * (4 << p) + 1) * 8 + 16, 1'b1)
      `CHK(watchdog_reset_o, 1'b1)
      `CHK(lp_wakeup_o, (p < 2))
      @(posedge mclk_i);
      `CHK(lp_wakeup_o, 1'b0)
    end
    standby_i         <= 1'b0;
    deep_stop_state_i <= 1'b0;
    // Hardware start by strap
    do_reset(1'b1);
    repeat (3) @(posedge mclk_i);
    apb(1'b0, dwu_pkg::OFS_IND_STATUS, 32'h0000_0000);
    `CHK(rd[12], 1'b1)
    // Window: warning at floor, refresh inside window, then late expiry
    do_reset(1'b0);
    apb(1'b1, dwu_pkg::OFS_WIN_CFG, 32'h0000_017F);
    apb(1'b1, dwu_pkg::OFS_WIN_CTRL, 32'h0000_00C1);
    wait_cnt(7'h40);
    `CHK(rd[6:0], 7'h40)
    `CHK(early_warning_interrupt_o, 1'b1)
    apb(1'b1, dwu_pkg::OFS_WIN_STATUS, 32'h0000_0001);
    @(posedge mclk_i);
    `CHK(early_warning_interrupt_o, 1'b0)
    apb(1'b1, dwu_pkg::OFS_WIN_CTRL, 32'h0000_00C1);
    apb(1'b0, dwu_pkg::OFS_WIN_CTRL, 32'h0000_0000);
    `CHK(rd[7:0], 8'hC1)
    `CHK(watchdog_reset_o, 1'b0)
    wait_cnt(7'h40);
    wait_rst(4200, n);
    `CHK(watchdog_reset_o, 1'b1)
    apb(1'b0, dwu_pkg::OFS_WIN_STATUS, 32'h0000_0000);
    `CHK(rd[1], 1'b1)
    // Window: reload above window value
    do_reset(1'b0);
    apb(1'b1, dwu_pkg::OFS_WIN_CFG, 32'h0000_0050);
    apb(1'b1, dwu_pkg::OFS_WIN_CTRL, 32'h0000_00FF);
    repeat (3) @(posedge mclk_i);
    `CHK(watchdog_reset_o, 1'b0)
    apb(1'b1, dwu_pkg::OFS_WIN_CTRL, 32'h0000_00C5);
    wait_rst(4, n);
    `CHK(watchdog_reset_o, 1'b1)
    wrap_up();
  end
endmodule
`default_nettype wire
